// [common/spf_defines.svh]
`ifndef SPF_DEFINES_SVH
`define SPF_DEFINES_SVH

// Instruction byte values.
`define SPF_OP_READ 8'h03
`define SPF_OP_STAT_RD 8'h05
`define SPF_OP_STAT_WR 8'h01
`define SPF_OP_PAGE_WRITE 8'h0A
`define SPF_OP_PAGE_PROG 8'h02
`define SPF_OP_PAGE_ERASE 8'hDB
`define SPF_OP_SUBS_ERASE 8'h20
`define SPF_OP_SECT_ERASE 8'hD8
`define SPF_OP_BULK_ERASE 8'hC7

// Array geometry: 8 sectors of 16 subsectors of 16 pages of 256 bytes.
`define SPF_ARRAY_W 19
`define SPF_SECT_HI 18
`define SPF_SECT_LO 16
`define SPF_PAGE_BYTES 9'h100
`define SPF_BYTE_W 8

// Serial framing.
`define SPF_BIT_LAST 3'h7
`define SPF_ADDR_LAST 2'h2

// Status byte layout.
`define SPF_ST_SWD 7
`define SPF_ST_BP_HI 4
`define SPF_ST_BP_LO 2
`define SPF_ST_BUSY 0

// Synchroniser lanes and their values after reset. The select lane starts
// low, so a select that is already low at release is not seen as a fall.
`define SPF_PIN_SCK 0
`define SPF_PIN_CS 1
`define SPF_PIN_MOSI 2
`define SPF_PIN_RST 3
`define SPF_PIN_LOCK 4
`define SPF_PIN_IDLE 5'h18

// Protected sector masks, top sectors first.
`define SPF_PROT_NONE 8'h00
`define SPF_PROT_TOP1 8'h80
`define SPF_PROT_TOP2 8'hC0
`define SPF_PROT_TOP4 8'hF0
`define SPF_PROT_ALL 8'hFF

`endif

// [common/spf_pkg.sv]
`default_nettype none
package spf_pkg;
`include "spf_defines.svh"

typedef enum logic [2:0] {
    KIND_PAGE_WRITE,
    KIND_PAGE_PROG,
    KIND_PAGE_ERASE,
    KIND_SUBS_ERASE,
    KIND_SECT_ERASE,
    KIND_BULK_ERASE
} spf_kind_t;

typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DATA,
    ST_READ,
    ST_STAT_OUT,
    ST_STAT_IN,
    ST_IGNORE
} spf_state_t;

typedef struct packed {
    spf_kind_t kind;
    logic [`SPF_ARRAY_W-1:0] addr;
    logic [8:0] count;
} spf_op_t;

typedef struct packed {
    logic first;
    logic [7:0] offset;
    logic [7:0] data;
} spf_wbyte_t;

endpackage
`default_nettype wire

// [design/spf_buf2.sv]
`timescale 1ns/1ps
`default_nettype none
module spf_buf2 #(
    parameter int W = 8
) (
    // Clock and control
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] ent_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] cnt_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data = ent_reg[rd_ptr_reg];
    assign push = clk_en && in_valid && in_ready;
    assign pop = clk_en && out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            ent_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 2'h1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 2'h1;
            end
        end
    end

    buf_bound_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cnt_reg <= 2'h2) else $error("buffer count out of range");
    buf_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffer head changed while stalled");
endmodule // spf_buf2
`default_nettype wire

// [design/spf_top.sv]
// Notes on behaviour
// - Output bit changes on serial clock fall.
// - Input bits sampled on serial clock rise.
// - Deselected: output pin stays high impedance.
// - Deselected and idle means standby power.
// - Select low means active power mode.
// - No instruction before first select fall.
// - Reset pin high: normal operation.
// - Reset pin low: reset mode, output floats.
// - Reset during internal cycle may lose data.
// - Page write/program takes 1 to 256 bytes.
// - Page write is erase then program.
// - Eight sectors of sixteen subsectors each.
// - Page 256 bytes, boundaries from low bits.
// - Erase page, subsector, sector or whole array.
// - Protection granularity is one sector.
// - Only protect bits and write-disable writable.
// - Lock pin with write-disable freezes protection.
// - Subsector erase addresses 4-Kbyte units.
// - Both idle-low and idle-high clock modes.
// - Lock pin low protects top 256 pages.
`timescale 1ns/1ps
`default_nettype none
module spf_top
    import spf_pkg::*;
(
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Serial pins
    input wire logic sck_pin,
    input wire logic cs_n_pin,
    input wire logic mosi_pin,
    input wire logic hw_reset_n_pin,
    input wire logic top_lock_n,
    output logic miso_o,
    output logic miso_oe,
    // Array operations
    input wire logic cycle_busy,
    output logic op_valid,
    output spf_op_t op_out,
    output logic cycle_abort,
    // Array reads
    output logic rd_req,
    output logic [`SPF_ARRAY_W-1:0] rd_addr,
    input wire logic [7:0] rd_data,
    // Array write data
    output logic wr_valid,
    input wire logic wr_ready,
    output spf_wbyte_t wr_byte,
    // Status
    output logic power_active,
    output logic data_overrun,
    output logic [2:0] block_protect,
    output logic status_write_disable
);
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic [4:0] pin_prev_reg;
    logic sck_s, cs_s, mosi_s, rst_s, lock_s;
    logic rise, fall, cs_fall, cs_rise, frame_rst, byte_done;
    logic [7:0] byte_in;
    spf_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_in_reg;
    logic [7:0] opcode_reg;
    logic [23:0] addr_reg;
    logic [1:0] addr_cnt_reg;
    logic [8:0] data_cnt_reg;
    logic complete_reg;
    logic [7:0] stat_pend_reg;
    logic [7:0] miso_sr_reg;
    logic [7:0] next_byte_reg;
    logic rise_seen_reg, out_en_reg, rd_req_reg, rd_fetch_reg;
    logic [`SPF_ARRAY_W-1:0] rd_addr_reg;
    logic [2:0] bp_reg;
    logic swd_reg;
    logic op_valid_reg, abort_reg, power_reg, overrun_reg;
    spf_op_t op_reg;
    logic addr_done, read_start, read_load, buf_in_valid, buf_in_ready;
    logic [7:0] status_byte, prot_mask;
    logic is_array_op, prot_hit;
    spf_kind_t kind;
    spf_wbyte_t buf_in_data;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection.
    // The serial clock is sampled, so it must stay well below clk_sys / 4.

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_reg <= `SPF_PIN_IDLE;
            pin_sync_reg <= `SPF_PIN_IDLE;
            pin_prev_reg <= `SPF_PIN_IDLE;
        end else if (clk_en) begin
            pin_meta_reg <= {top_lock_n, hw_reset_n_pin, mosi_pin, cs_n_pin,
                             sck_pin};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign sck_s = pin_sync_reg[`SPF_PIN_SCK];
    assign cs_s = pin_sync_reg[`SPF_PIN_CS];
    assign mosi_s = pin_sync_reg[`SPF_PIN_MOSI];
    assign rst_s = pin_sync_reg[`SPF_PIN_RST];
    assign lock_s = pin_sync_reg[`SPF_PIN_LOCK];
    // Both clock modes share the same edges; only the idle level differs.
    assign rise = clk_en && sck_s && !pin_prev_reg[`SPF_PIN_SCK];
    assign fall = clk_en && !sck_s && pin_prev_reg[`SPF_PIN_SCK];
    assign cs_fall = clk_en && !cs_s && pin_prev_reg[`SPF_PIN_CS];
    assign cs_rise = clk_en && cs_s && !pin_prev_reg[`SPF_PIN_CS];
    assign frame_rst = cs_s || !rst_s;
    assign byte_done = rise && !frame_rst && !cs_fall &&
                       (bit_cnt_reg == `SPF_BIT_LAST);
    assign byte_in = {shift_in_reg[6:0], mosi_s};
    assign addr_done = byte_done && (state_reg == ST_ADDR) &&
                       (addr_cnt_reg == `SPF_ADDR_LAST);
    assign read_start = addr_done && (opcode_reg == `SPF_OP_READ);

    ////////////////////////////////////////////////////////////////////////
    // Instruction framing.

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 3'h0;
            shift_in_reg <= 8'h00;
            opcode_reg <= 8'h00;
            addr_reg <= 24'h00_0000;
            addr_cnt_reg <= 2'h0;
            data_cnt_reg <= 9'h000;
            complete_reg <= 1'b0;
            stat_pend_reg <= 8'h00;
        end else if (clk_en) begin
            if (frame_rst) begin
                state_reg <= ST_IDLE;
                bit_cnt_reg <= 3'h0;
                addr_cnt_reg <= 2'h0;
                data_cnt_reg <= 9'h000;
                complete_reg <= 1'b0;
            end else if (cs_fall) begin
                state_reg <= ST_CMD;
                bit_cnt_reg <= 3'h0;
            end else if (rise && state_reg != ST_IDLE) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_in_reg <= byte_in;
                if (bit_cnt_reg == `SPF_BIT_LAST) begin
                    case (state_reg)
                        ST_CMD: begin
                            opcode_reg <= byte_in;
                            case (byte_in)
                                `SPF_OP_READ, `SPF_OP_PAGE_WRITE,
                                `SPF_OP_PAGE_PROG, `SPF_OP_PAGE_ERASE,
                                `SPF_OP_SUBS_ERASE, `SPF_OP_SECT_ERASE: begin
                                    state_reg <= ST_ADDR;
                                end
                                `SPF_OP_BULK_ERASE: begin
                                    state_reg <= ST_IGNORE;
                                    complete_reg <= 1'b1;
                                end
                                `SPF_OP_STAT_RD: state_reg <= ST_STAT_OUT;
                                `SPF_OP_STAT_WR: state_reg <= ST_STAT_IN;
                                default: state_reg <= ST_IGNORE;
                            endcase
                        end
                        ST_ADDR: begin
                            addr_reg <= {addr_reg[15:0], byte_in};
                            addr_cnt_reg <= addr_cnt_reg + 2'h1;
                            if (addr_cnt_reg == `SPF_ADDR_LAST) begin
                                if (opcode_reg == `SPF_OP_READ) begin
                                    state_reg <= ST_READ;
                                end else if (opcode_reg == `SPF_OP_PAGE_WRITE ||
                                    opcode_reg == `SPF_OP_PAGE_PROG) begin
                                    state_reg <= ST_DATA;
                                end else begin
                                    state_reg <= ST_IGNORE;
                                    complete_reg <= 1'b1;
                                end
                            end
                        end
                        ST_DATA: begin
                            // The count holds at 256, so bytes past 256 all land on the start offset.
                            if (buf_in_ready) begin
                                complete_reg <= 1'b1;
                                if (data_cnt_reg != `SPF_PAGE_BYTES) begin
                                    data_cnt_reg <= data_cnt_reg + 9'h001;
                                end
                            end else begin
                                complete_reg <= 1'b0;
                                state_reg <= ST_IGNORE;
                            end
                        end
                        ST_STAT_IN: begin
                            stat_pend_reg <= byte_in;
                            complete_reg <= 1'b1;
                            state_reg <= ST_IGNORE;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial output and array reads.

    always_comb begin
        status_byte = 8'h00;
        status_byte[`SPF_ST_SWD] = swd_reg;
        status_byte[`SPF_ST_BP_HI:`SPF_ST_BP_LO] = bp_reg;
        status_byte[`SPF_ST_BUSY] = cycle_busy;
    end

    assign read_load = fall && rise_seen_reg && !frame_rst &&
                       bit_cnt_reg == 3'h0 && state_reg == ST_READ;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            miso_sr_reg <= 8'h00;
            rise_seen_reg <= 1'b0;
            out_en_reg <= 1'b0;
        end else if (clk_en) begin
            if (frame_rst || cs_fall) begin
                rise_seen_reg <= 1'b0;
                out_en_reg <= 1'b0;
            end else if (rise) begin
                rise_seen_reg <= 1'b1;
            end
            // An idle-high clock falls once before its first rise; that
            // edge must not shift anything out.
            if (fall && rise_seen_reg && !frame_rst) begin
                if (bit_cnt_reg == 3'h0 && state_reg == ST_STAT_OUT) begin
                    miso_sr_reg <= status_byte;
                    out_en_reg <= 1'b1;
                end else if (read_load) begin
                    miso_sr_reg <= next_byte_reg;
                    out_en_reg <= 1'b1;
                end else begin
                    miso_sr_reg <= {miso_sr_reg[6:0], 1'b0};
                end
            end
        end
    end

    // One byte is always prefetched; rd_data is taken one enabled cycle after rd_req.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_req_reg <= 1'b0;
            rd_fetch_reg <= 1'b0;
            rd_addr_reg <= '0;
            next_byte_reg <= 8'h00;
        end else if (clk_en) begin
            rd_req_reg <= read_start || read_load;
            rd_fetch_reg <= rd_req_reg;
            if (read_start) begin
                rd_addr_reg <= {addr_reg[10:0], byte_in};
            end else if (rd_req_reg) begin
                rd_addr_reg <= rd_addr_reg + 1'b1;
            end
            if (rd_fetch_reg) begin
                next_byte_reg <= rd_data;
            end
        end
    end

    assign miso_o = miso_sr_reg[7];
    assign miso_oe = out_en_reg && !cs_s && rst_s;
    assign rd_req = rd_req_reg;
    assign rd_addr = rd_addr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Write data buffer.

    assign buf_in_valid = byte_done && state_reg == ST_DATA;
    assign buf_in_data.first = (data_cnt_reg == 9'h000);
    assign buf_in_data.offset = addr_reg[7:0] + data_cnt_reg[7:0];
    assign buf_in_data.data = byte_in;

    spf_buf2 #(
        .W($bits(spf_wbyte_t))
    ) u_buf (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in_data),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_byte)
    );

    ////////////////////////////////////////////////////////////////////////
    // Protection and operation issue.

    always_comb begin
        case (bp_reg)
            3'h0: prot_mask = `SPF_PROT_NONE;
            3'h1: prot_mask = `SPF_PROT_TOP1;
            3'h2: prot_mask = `SPF_PROT_TOP2;
            3'h3: prot_mask = `SPF_PROT_TOP4;
            default: prot_mask = `SPF_PROT_ALL;
        endcase
        if (!lock_s) begin
            prot_mask = prot_mask | `SPF_PROT_TOP1;
        end
    end

    always_comb begin
        is_array_op = 1'b1;
        case (opcode_reg)
            `SPF_OP_PAGE_WRITE: kind = KIND_PAGE_WRITE;
            `SPF_OP_PAGE_PROG: kind = KIND_PAGE_PROG;
            `SPF_OP_PAGE_ERASE: kind = KIND_PAGE_ERASE;
            `SPF_OP_SUBS_ERASE: kind = KIND_SUBS_ERASE;
            `SPF_OP_SECT_ERASE: kind = KIND_SECT_ERASE;
            `SPF_OP_BULK_ERASE: kind = KIND_BULK_ERASE;
            default: begin
                kind = KIND_PAGE_PROG;
                is_array_op = 1'b0;
            end
        endcase
        if (kind == KIND_BULK_ERASE) begin
            prot_hit = |prot_mask;
        end else begin
            prot_hit = prot_mask[addr_reg[`SPF_SECT_HI:`SPF_SECT_LO]];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            op_valid_reg <= 1'b0;
            op_reg <= '0;
            bp_reg <= 3'h0;
            swd_reg <= 1'b0;
        end else if (clk_en) begin
            op_valid_reg <= 1'b0;
            if (cs_rise && rst_s && complete_reg) begin
                if (is_array_op && !prot_hit && !cycle_busy) begin
                    op_valid_reg <= 1'b1;
                    op_reg.kind <= kind;
                    op_reg.addr <= addr_reg[`SPF_ARRAY_W-1:0];
                    op_reg.count <= data_cnt_reg;
                end
                if (opcode_reg == `SPF_OP_STAT_WR && !(swd_reg && !lock_s)) begin
                    bp_reg <= stat_pend_reg[`SPF_ST_BP_HI:`SPF_ST_BP_LO];
                    swd_reg <= stat_pend_reg[`SPF_ST_SWD];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            abort_reg <= 1'b0;
            power_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else if (clk_en) begin
            abort_reg <= !rst_s && pin_prev_reg[`SPF_PIN_RST] &&
                         cycle_busy;
            power_reg <= !cs_s || cycle_busy;
            if (buf_in_valid && !buf_in_ready) begin
                overrun_reg <= 1'b1;
            end else if (cs_fall) begin
                overrun_reg <= 1'b0;
            end
        end
    end

    assign op_valid = op_valid_reg;
    assign op_out = op_reg;
    assign cycle_abort = abort_reg;
    assign power_active = power_reg;
    assign data_overrun = overrun_reg;
    assign block_protect = bp_reg;
    assign status_write_disable = swd_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    out_deselect_a: assert property (cs_s |-> !miso_oe)
        else $error("output driven while deselected");
    out_reset_a: assert property (!rst_s |-> !miso_oe)
        else $error("output driven in reset mode");
    out_edge_a: assert property ($changed(miso_sr_reg) |-> $past(fall))
        else $error("output moved without clock fall");
    op_release_a: assert property (op_valid |-> $past(cs_rise) ||
        $past(op_valid && !clk_en))
        else $error("operation issued outside select release");
    idle_wait_a: assert property (clk_en && state_reg == ST_IDLE
        && !cs_fall |=> state_reg == ST_IDLE)
        else $error("left idle without select fall");
    page_count_a: assert property (op_valid && (op_out.kind ==
        KIND_PAGE_WRITE || op_out.kind == KIND_PAGE_PROG) |->
        op_out.count != 9'h000 && op_out.count <= `SPF_PAGE_BYTES)
        else $error("page byte count out of range");
    power_on_a: assert property (clk_en && !cs_s |=> power_active)
        else $error("selected but not active");
    power_off_a: assert property (clk_en && cs_s && !cycle_busy
        |=> !power_active) else $error("idle and deselected but active");
    protect_a: assert property (op_valid && op_out.kind !=
        KIND_BULK_ERASE |-> !$past(prot_mask[addr_reg[`SPF_SECT_HI:
        `SPF_SECT_LO]])) else $error("operation on protected sector");
    status_hold_a: assert property ($changed(bp_reg) ||
        $changed(swd_reg) |-> $past(cs_rise) && !$past(swd_reg && !lock_s))
        else $error("status bits changed without allowed write");

    page_write_c: cover property (op_valid && op_out.kind == KIND_PAGE_WRITE);
    bulk_erase_c: cover property (op_valid && op_out.kind == KIND_BULK_ERASE);
    read_byte_c: cover property (read_load ##[1:100] read_load);
    stat_write_c: cover property ($changed(bp_reg));
endmodule // spf_top
`default_nettype wire

// [testbench/spf_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module spf_master_model (
    // Clock
    input wire logic clk_sys,
    // Serial pins
    output logic sck_pin,
    output logic cs_n_pin,
    output logic mosi_pin,
    input wire logic miso_o,
    input wire logic miso_oe
);
    logic [7:0] rx;
    logic mode3;
    initial begin
        sck_pin = 1'b0;
        cs_n_pin = 1'b0;
        mosi_pin = 1'b0;
        rx = 8'h00;
        mode3 = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic open(input logic m3);
        mode3 = m3;
        sck_pin = m3;
        tick(2);
        cs_n_pin = 1'b0;
        tick(4);
    endtask
    // A released output reads back as the inverse of its last bit, so a float cannot pass a check of an unchanged bit.
    task automatic xfer(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--) begin
            sck_pin = 1'b0;
            mosi_pin = tx[i];
            tick(4);
            sck_pin = 1'b1;
            tick(3);
            rx[i] = miso_oe ? miso_o : ~rx[i];
            tick(1);
        end
    endtask
    task automatic close();
        sck_pin = mode3;
        tick(4);
        cs_n_pin = 1'b1;
        mosi_pin = ~mosi_pin;
        tick(12);
    endtask
endmodule // spf_master_model
`default_nettype wire

// [testbench/test_serial_paged_flash_interface.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin \
    bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_serial_paged_flash_interface;
    import spf_pkg::*;
    logic clk_sys, reset_n, clk_en, sck, cs_n, mosi, hw_rst_n, lock_n;
    logic miso_o, miso_oe, busy, op_valid, abort, rd_req, wr_valid;
    logic wr_ready, pwr, ovr, swd, stall;
    logic [2:0] bp;
    logic [18:0] rd_addr;
    logic [7:0] rd_data;
    spf_op_t op_out, last_op;
    spf_wbyte_t wr_byte, exp_b;
    spf_wbyte_t wq[$];
    int bad_count, n_tests, ops, seed, base, aborts, gap;
    spf_kind_t kinds[4] = '{KIND_PAGE_ERASE, KIND_SUBS_ERASE,
        KIND_SECT_ERASE, KIND_BULK_ERASE};
    logic [7:0] codes[4] = '{8'hDB, 8'h20, 8'hD8, 8'hC7};
    spf_top spf_top_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .clk_en(clk_en), .sck_pin(sck), .cs_n_pin(cs_n), .mosi_pin(mosi),
        .hw_reset_n_pin(hw_rst_n), .top_lock_n(lock_n), .miso_o(miso_o),
        .miso_oe(miso_oe), .cycle_busy(busy), .op_valid(op_valid),
        .op_out(op_out), .cycle_abort(abort), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_byte(wr_byte), .power_active(pwr),
        .data_overrun(ovr), .block_protect(bp),
        .status_write_disable(swd));
    spf_master_model master_inst (.clk_sys(clk_sys), .sck_pin(sck),
        .cs_n_pin(cs_n), .mosi_pin(mosi), .miso_o(miso_o),
        .miso_oe(miso_oe));
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Array model: read data is a fixed function of the address.
    always @(posedge clk_sys) begin
        if (rd_req) rd_data <= rd_addr[7:0] ^ 8'h5A;
        if (op_valid && clk_en) ops <= ops + 1;
        if (op_valid && clk_en) last_op <= op_out;
        if (abort && clk_en) aborts <= aborts + 1;
        if (wr_valid && wr_ready && clk_en) wq.push_back(wr_byte);
    end
    always @(negedge clk_sys) wr_ready <= !stall && 1'($random(seed));
    // Enable drops for single cycles at least eight cycles apart, so the
    // read prefetch still beats the next serial clock fall.
    always @(negedge clk_sys) begin
        gap = clk_en ? gap + 1 : 0;
        clk_en <= gap < 8 || 1'($random(seed));
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        give_verdict();
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Sends op and address bytes; nd data bytes; cut limits the address bytes to the first cut.
    task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                       input int nd, input int cut);
        master_inst.open(1'($random(seed)));
        base = ops;
        master_inst.xfer(op);
        for (int i = 0; i < 3 && i < cut; i++) master_inst.xfer(a[23-8*i-:8]);
        for (int i = 0; i < nd; i++) master_inst.xfer(8'hA0 + 8'(i));
        master_inst.close();
    endtask
    initial begin
        seed = 37;
        reset_n = 1'b0;
        clk_en = 1'b1;
        hw_rst_n = 1'b1;
        lock_n = 1'b1;
        busy = 1'b0;
        rd_data = 8'h00;
        ops = 0;
        aborts = 0;
        stall = 1'b0;
        repeat (5) @(negedge clk_sys);
        reset_n = 1'b1;
        master_inst.tick(4);
        master_inst.xfer(8'hC7);
        master_inst.close();
        `CHK("pwrup_op", 0, ops)
        `CHK("standby", 1'b0, pwr)
        `CHK("oe_idle", 1'b0, miso_oe)
        cmd(8'h0A, 24'h01_2345, 3, 3);
        `CHK("pw_op", spf_op_t'{KIND_PAGE_WRITE, 19'h1_2345, 9'd3}, last_op)
        for (int i = 0; i < 200 && wq.size() < 3; i++) master_inst.tick(1);
        `CHK("pw_cnt", 3, wq.size())
        for (int i = 0; i < 3 && i < wq.size(); i++) begin
            exp_b = '{i == 0, 8'h45 + 8'(i), 8'hA0 + 8'(i)};
            `CHK("pw_byte", exp_b, wq[i])
        end
        stall = 1'b1;
        cmd(8'h0A, 24'h00_0000, 3, 3);
        `CHK("ovr_set", 1'b1, ovr)
        `CHK("ovr_op", base, ops)
        stall = 1'b0;
        for (int k = 0; k < 4; k++) begin
            cmd(codes[k], 24'h07_F100, 0, k == 3 ? 0 : 3);
            `CHK("er_kind", kinds[k], last_op.kind)
            if (k < 3) `CHK("er_addr", 19'h7_F100, last_op.addr)
        end
        `CHK("ovr_clr", 1'b0, ovr)
        cmd(8'h02, 24'h00_0000, 0, 2);
        `CHK("abort_op", base, ops)
        busy = 1'b1;
        cmd(8'hDB, 24'h00_0100, 0, 3);
        `CHK("busy_op", base, ops)
        `CHK("busy_pwr", 1'b1, pwr)
        hw_rst_n = 1'b0;
        master_inst.tick(6);
        `CHK("abort", 1, aborts)
        hw_rst_n = 1'b1;
        master_inst.tick(4);
        busy = 1'b0;
        lock_n = 1'b0;
        cmd(8'hD8, 24'h07_0000, 0, 3);
        `CHK("lock_op", base, ops)
        cmd(8'hD8, 24'h06_0000, 0, 3);
        `CHK("unlock_op", base + 1, ops)
        cmd(8'h01, 24'hFF_0000, 0, 1);
        `CHK("st_bp", 3'h7, bp)
        `CHK("st_swd", 1'b1, swd)
        cmd(8'h01, 24'h00_0000, 0, 1);
        `CHK("st_lock", 3'h7, bp)
        cmd(8'hD8, 24'h00_0000, 0, 3);
        `CHK("st_prot", base, ops)
        master_inst.open(1'b1);
        master_inst.xfer(8'h05);
        master_inst.xfer(8'h00);
        `CHK("st_read", 8'h9C, master_inst.rx)
        master_inst.close();
        lock_n = 1'b1;
        cmd(8'h01, 24'h00_0000, 0, 1);
        `CHK("st_free", 1'b0, swd)
        master_inst.open(1'b0);
        `CHK("active", 1'b1, pwr)
        master_inst.xfer(8'h03);
        master_inst.xfer(8'h00);
        master_inst.xfer(8'h00);
        master_inst.xfer(8'h10);
        master_inst.xfer(8'h00);
        `CHK("rd0", 8'h4A, master_inst.rx)
        master_inst.xfer(8'h00);
        `CHK("rd1", 8'h4B, master_inst.rx)
        hw_rst_n = 1'b0;
        master_inst.tick(6);
        `CHK("rst_oe", 1'b0, miso_oe)
        master_inst.close();
        hw_rst_n = 1'b1;
        master_inst.tick(8);
        `CHK("abort_idle", 1, aborts)
        give_verdict();
    end
endmodule // test_serial_paged_flash_interface
`default_nettype wire
